// >>> dwg_pkg.sv
// Package with register map, field layout and shared types of the waveform source selector.
package dwg_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0]  ADDR_SEL_CH3_CH4 = 8'h26;
    localparam logic [7:0]  ADDR_SEL_CH1_CH2 = 8'h27;
    localparam logic [7:0]  ADDR_TIMEBASE    = 8'h28;

    localparam logic [15:0] SEL_CH3_CH4_RST  = 16'h0101;
    localparam logic [15:0] SEL_CH1_CH2_RST  = 16'h0101;
    localparam logic [15:0] TIMEBASE_RST     = 16'h0111;
    localparam logic [15:0] SEL_CH3_CH4_MASK = 16'h3333;
    localparam logic [15:0] SEL_CH1_CH2_MASK = 16'h3F3F;
    localparam logic [15:0] TIMEBASE_MASK    = 16'h0FFF;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int SRC_LO_POS     = 0;
    localparam int SRC_HI_POS     = 8;
    localparam int BUILTIN_LO_POS = 4;
    localparam int BUILTIN_HI_POS = 12;
    localparam int SUM13_POS      = 2;
    localparam int FORCE3_POS     = 3;
    localparam int SUM24_POS      = 10;
    localparam int FORCE4_POS     = 11;
    localparam int HOLD_POS       = 8;
    localparam int PERIOD_POS     = 4;
    localparam int DELAY_POS      = 0;

    localparam int unsigned NCH = 4;

    typedef enum logic [1:0] {
        SRC_RAM       = 2'h0,
        SRC_BUILTIN   = 2'h1,
        SRC_GATED     = 2'h2,
        SRC_MODULATED = 2'h3
    } dwg_src_t;

    typedef enum logic [1:0] {
        BLT_CONSTANT = 2'h0,
        BLT_RAMP     = 2'h1,
        BLT_NOISE    = 2'h2,
        BLT_SYNTH    = 2'h3
    } dwg_builtin_t;

    // Sample word of all four channels, index 0 is channel 1.
    typedef struct packed {
        logic [3:0][11:0] ch;
    } dwg_frame_t;

    // Decoded per-channel configuration.
    typedef struct packed {
        dwg_src_t     src;
        dwg_builtin_t blt;
    } dwg_chcfg_t;

endpackage

// >>> dwg_source_select.sv
// Waveform source selector and pattern timebase for a four-channel waveform generator.
//
// Notes on behaviour
// - The source selector picks RAM, builtin, gated builtin or RAM-modulated builtin.
// - Channel 4 source selector sits at bits 9:8 of the ch3/ch4 register, reset 1.
// - Channel 3 source selector sits at bits 1:0 of the ch3/ch4 register, reset 1.
// - Channel 2 and 1 source selectors sit at bits 9:8 and 1:0 of ch1/ch2, reset 1.
// - The builtin selector picks constant, ramp, noise or synthesizer.
// - Builtin selectors sit at bits 13:12 and 5:4 and reset to constant.
// - Bit 11 of the ch1/ch2 register forces channel 4 to its constant level.
// - Bit 3 of the ch1/ch2 register forces channel 3 to its constant level.
// - With the 2+4 sum bit set channel 2 outputs ch2 plus ch4, channel 4 unchanged.
// - With the 1+3 sum bit set channel 1 outputs ch1 plus ch3, channel 3 unchanged.
// - Hold field 11:8 keeps each RAM sample that many clocks, zero meaning 16, reset 1.
// - Period scale field 7:4 gives clocks per period count, zero meaning 16, reset 1.
// - Delay scale field 3:0 gives clocks per delay count, zero meaning 16, reset 1.
// - Constant levels are 12-bit two's complement at bits 15:4 of their registers.
// - Playback runs only while the run bit is set.
`timescale 1ns/1ns
`default_nettype none
module dwg_source_select (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic               cfg_wr,
    input  wire logic               cfg_rd,
    input  wire logic [7:0]         cfg_addr,
    input  wire logic [15:0]        cfg_wdata,
    output logic      [15:0]        cfg_rdata,
    input  wire logic               run,
    input  wire logic [3:0][15:0]   fixed_level_reg,
    input  wire logic [3:0][15:0]   launch_delay,
    input  wire logic [15:0]        pattern_period,
    input  wire dwg_pkg::dwg_frame_t ram_data,
    input  wire dwg_pkg::dwg_frame_t ramp_data,
    input  wire dwg_pkg::dwg_frame_t synth_data,
    output logic                    ram_advance,
    output logic                    out_valid,
    input  wire logic               out_ready,
    output dwg_pkg::dwg_frame_t     out_data,
    output logic                    pattern_active
);

    // ****************************************
    // Configuration registers
    // ****************************************
    logic [15:0] sel34_r;
    logic [15:0] sel12_r;
    logic [15:0] tb_r;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sel34_r <= dwg_pkg::SEL_CH3_CH4_RST;
            sel12_r <= dwg_pkg::SEL_CH1_CH2_RST;
            tb_r    <= dwg_pkg::TIMEBASE_RST;
        end else if (cfg_wr) begin
            if (cfg_addr == dwg_pkg::ADDR_SEL_CH3_CH4) begin
                sel34_r <= cfg_wdata & dwg_pkg::SEL_CH3_CH4_MASK;
            end else if (cfg_addr == dwg_pkg::ADDR_SEL_CH1_CH2) begin
                sel12_r <= cfg_wdata & dwg_pkg::SEL_CH1_CH2_MASK;
            end else if (cfg_addr == dwg_pkg::ADDR_TIMEBASE) begin
                tb_r <= cfg_wdata & dwg_pkg::TIMEBASE_MASK;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg_rdata <= 16'h0000;
        end else if (cfg_rd) begin
            if (cfg_addr == dwg_pkg::ADDR_SEL_CH3_CH4) begin
                cfg_rdata <= sel34_r;
            end else if (cfg_addr == dwg_pkg::ADDR_SEL_CH1_CH2) begin
                cfg_rdata <= sel12_r;
            end else if (cfg_addr == dwg_pkg::ADDR_TIMEBASE) begin
                cfg_rdata <= tb_r;
            end else begin
                cfg_rdata <= 16'h0000;
            end
        end
    end

    // Decoded fields; index 0 is channel 1.
    dwg_pkg::dwg_chcfg_t [3:0] cfg;
    always_comb begin
        cfg[0].src = dwg_pkg::dwg_src_t'(sel12_r[dwg_pkg::SRC_LO_POS +: 2]);
        cfg[1].src = dwg_pkg::dwg_src_t'(sel12_r[dwg_pkg::SRC_HI_POS +: 2]);
        cfg[2].src = dwg_pkg::dwg_src_t'(sel34_r[dwg_pkg::SRC_LO_POS +: 2]);
        cfg[3].src = dwg_pkg::dwg_src_t'(sel34_r[dwg_pkg::SRC_HI_POS +: 2]);
        cfg[0].blt = dwg_pkg::dwg_builtin_t'(sel12_r[dwg_pkg::BUILTIN_LO_POS +: 2]);
        cfg[1].blt = dwg_pkg::dwg_builtin_t'(sel12_r[dwg_pkg::BUILTIN_HI_POS +: 2]);
        cfg[2].blt = dwg_pkg::dwg_builtin_t'(sel34_r[dwg_pkg::BUILTIN_LO_POS +: 2]);
        cfg[3].blt = dwg_pkg::dwg_builtin_t'(sel34_r[dwg_pkg::BUILTIN_HI_POS +: 2]);
    end

    wire logic force3 = sel12_r[dwg_pkg::FORCE3_POS];
    wire logic force4 = sel12_r[dwg_pkg::FORCE4_POS];
    wire logic sum13  = sel12_r[dwg_pkg::SUM13_POS];
    wire logic sum24  = sel12_r[dwg_pkg::SUM24_POS];

    // Turns a four-bit count field into a period, zero meaning 16.
    function automatic logic [4:0] scale_of(input logic [3:0] f);
        scale_of = (f == 4'h0) ? 5'h10 : {1'b0, f};
    endfunction

    // ****************************************
    // Timebase
    // ****************************************
    logic [4:0]  hold_cnt_r;
    logic [4:0]  pbase_cnt_r;
    logic [4:0]  dbase_cnt_r;
    logic [15:0] period_cnt_r;
    logic [15:0] delay_cnt_r;
    logic        stall;
    wire logic [4:0] hold_len  = scale_of(tb_r[dwg_pkg::HOLD_POS +: 4]);
    wire logic [4:0] pbase_len = scale_of(tb_r[dwg_pkg::PERIOD_POS +: 4]);
    wire logic [4:0] dbase_len = scale_of(tb_r[dwg_pkg::DELAY_POS +: 4]);
    wire logic hold_done  = (hold_cnt_r + 5'h01 >= hold_len);
    wire logic pbase_tick = (pbase_cnt_r + 5'h01 >= pbase_len);
    wire logic dbase_tick = (dbase_cnt_r + 5'h01 >= dbase_len);
    wire logic period_end = pbase_tick && (period_cnt_r + 16'h0001 >= pattern_period);

    // Holds each RAM sample hold_len clocks, then pulses the address advance.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hold_cnt_r  <= 5'h00;
            ram_advance <= 1'b0;
        end else if (!run) begin
            hold_cnt_r  <= 5'h00;
            ram_advance <= 1'b0;
        end else if (!stall) begin
            hold_cnt_r  <= hold_done ? 5'h00 : hold_cnt_r + 5'h01;
            ram_advance <= hold_done;
        end else begin
            ram_advance <= 1'b0;
        end
    end

    // Pattern period and start delay counters, in scaled units.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pbase_cnt_r  <= 5'h00;
            dbase_cnt_r  <= 5'h00;
            period_cnt_r <= 16'h0000;
            delay_cnt_r  <= 16'h0000;
        end else if (!run) begin
            pbase_cnt_r  <= 5'h00;
            dbase_cnt_r  <= 5'h00;
            period_cnt_r <= 16'h0000;
            delay_cnt_r  <= 16'h0000;
        end else if (!stall) begin
            pbase_cnt_r <= pbase_tick ? 5'h00 : pbase_cnt_r + 5'h01;
            dbase_cnt_r <= (dbase_tick || period_end) ? 5'h00 : dbase_cnt_r + 5'h01;
            if (period_end) begin
                period_cnt_r <= 16'h0000;
                delay_cnt_r  <= 16'h0000;
            end else begin
                if (pbase_tick) begin
                    period_cnt_r <= period_cnt_r + 16'h0001;
                end
                if (dbase_tick && delay_cnt_r != 16'hFFFF) begin
                    delay_cnt_r <= delay_cnt_r + 16'h0001;
                end
            end
        end
    end

    // ****************************************
    // Pseudorandom generator
    // ****************************************
    logic [15:0] lfsr_r;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lfsr_r <= 16'hACE1;
        end else if (run && !stall) begin
            lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        end
    end

    // ****************************************
    // Source selection
    // ****************************************
    function automatic logic [11:0] level_of(input logic [15:0] r);
        level_of = r[15:4];
    endfunction

    // Signed 12-bit product of two samples, keeping bits 22:11 of the full product.
    function automatic logic [11:0] modulate(input logic [11:0] a, input logic [11:0] b);
        logic signed [23:0] p;
        p = $signed(a) * $signed(b);
        modulate = p[22:11];
    endfunction

    function automatic logic [11:0] sat_add(input logic [11:0] a, input logic [11:0] b);
        logic signed [12:0] s;
        s = $signed({a[11], a}) + $signed({b[11], b});
        if (s > 13'sh07FF) begin
            sat_add = 12'h7FF;
        end else if (s < -13'sh0800) begin
            sat_add = 12'h800;
        end else begin
            sat_add = s[11:0];
        end
    endfunction

    dwg_pkg::dwg_frame_t chan;
    dwg_pkg::dwg_frame_t mixed;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            logic [11:0] blt;
            blt = 12'h000;
            case (cfg[i].blt)
                dwg_pkg::BLT_CONSTANT: blt = level_of(fixed_level_reg[i]);
                dwg_pkg::BLT_RAMP:     blt = ramp_data.ch[i];
                dwg_pkg::BLT_NOISE:    blt = lfsr_r[11:0];
                default:               blt = synth_data.ch[i];
            endcase
            case (cfg[i].src)
                dwg_pkg::SRC_RAM:     chan.ch[i] = ram_data.ch[i];
                dwg_pkg::SRC_BUILTIN: chan.ch[i] = blt;
                dwg_pkg::SRC_GATED:   chan.ch[i] = (delay_cnt_r >= launch_delay[i]) ? blt : 12'h000;
                default:              chan.ch[i] = modulate(blt, ram_data.ch[i]);
            endcase
        end
        if (force3) begin
            chan.ch[2] = level_of(fixed_level_reg[2]);
        end
        if (force4) begin
            chan.ch[3] = level_of(fixed_level_reg[3]);
        end
        mixed = chan;
        if (sum13) begin
            mixed.ch[0] = sat_add(chan.ch[0], chan.ch[2]);
        end
        if (sum24) begin
            mixed.ch[1] = sat_add(chan.ch[1], chan.ch[3]);
        end
    end

    // ****************************************
    // Two-entry output buffer
    // ****************************************
    // The output register takes a frame straight from the mixer while the buffer is empty,
    // so a receiver that stays ready gets one frame per clock and the timebase never stalls.
    dwg_pkg::dwg_frame_t buf_r [2];
    logic [1:0] count_r;
    logic       rd_idx_r;
    logic       wr_idx_r;
    wire logic in_valid = run;
    wire logic in_ready = (count_r != 2'h2);
    wire logic push     = in_valid && in_ready;
    wire logic take     = !out_valid || out_ready;
    wire logic deq      = take && (count_r != 2'h0);
    wire logic bypass   = take && (count_r == 2'h0) && push;
    wire logic enq      = push && !bypass;
    assign stall = !in_ready;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            buf_r[0] <= '0;
            buf_r[1] <= '0;
            count_r  <= 2'h0;
            rd_idx_r <= 1'b0;
            wr_idx_r <= 1'b0;
        end else begin
            if (enq) begin
                buf_r[wr_idx_r] <= mixed;
                wr_idx_r <= ~wr_idx_r;
            end
            if (deq) begin
                rd_idx_r <= ~rd_idx_r;
            end
            count_r <= count_r + {1'b0, enq} - {1'b0, deq};
        end
    end

    // Output stage loads the oldest buffered frame first, else the fresh one.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            out_valid      <= 1'b0;
            out_data       <= '0;
            pattern_active <= 1'b0;
        end else begin
            pattern_active <= run;
            if (take) begin
                if (count_r != 2'h0) begin
                    out_valid <= 1'b1;
                    out_data  <= buf_r[rd_idx_r];
                end else if (push) begin
                    out_valid <= 1'b1;
                    out_data  <= mixed;
                end else begin
                    out_valid <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    chk_ch4_reset_src: assert property (@(posedge mclk) $rose(!rst) |-> sel34_r[9:8] == 2'h1)
        else $error("ch4 source select not builtin after reset");
    chk_ch3_reset_src: assert property (@(posedge mclk) $rose(!rst) |-> sel34_r[1:0] == 2'h1)
        else $error("ch3 source select not builtin after reset");
    chk_ch12_reset: assert property (@(posedge mclk) $rose(!rst) |-> sel12_r == 16'h0101)
        else $error("ch1/ch2 select reset wrong");
    chk_builtin_reset: assert property (@(posedge mclk) $rose(!rst) |-> sel34_r[13:12] == 2'h0)
        else $error("builtin selector reset wrong");
    chk_tb_reset: assert property (@(posedge mclk) $rose(!rst) |-> tb_r == 16'h0111)
        else $error("timebase reset wrong");
    chk_force_ch4: assert property (@(posedge mclk) disable iff (rst)
        force4 |-> chan.ch[3] == fixed_level_reg[3][15:4])
        else $error("ch4 not forced to constant");
    chk_force_ch3: assert property (@(posedge mclk) disable iff (rst)
        force3 |-> chan.ch[2] == fixed_level_reg[2][15:4])
        else $error("ch3 not forced to constant");
    chk_sum_ch4_kept: assert property (@(posedge mclk) disable iff (rst)
        sum24 |-> mixed.ch[3] == chan.ch[3])
        else $error("ch4 altered by sum");
    chk_sum_ch3_kept: assert property (@(posedge mclk) disable iff (rst)
        sum13 |-> mixed.ch[2] == chan.ch[2])
        else $error("ch3 altered by sum");
    // Two free-running clocks with a hold of one.
    sequence seq_hold_one_run;
        run && !stall && hold_len == 5'h01 ##1 run && !stall;
    endsequence
    chk_hold_one: assert property (@(posedge mclk) disable iff (rst)
        seq_hold_one_run |-> ram_advance)
        else $error("hold of one clock not honoured");
    chk_stopped_idle: assert property (@(posedge mclk) disable iff (rst)
        !run |=> !ram_advance && hold_cnt_r == 5'h00)
        else $error("timebase active while stopped");

endmodule
`default_nettype wire

// >>> dwg_sink_model.sv
// Model of the converter cores that take frames from the stream port.
`timescale 1ns/1ns
`default_nettype none
module dwg_sink_model (
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire logic                stall,
    input  wire logic                out_valid,
    output logic                     out_ready,
    input  wire dwg_pkg::dwg_frame_t out_data,
    output dwg_pkg::dwg_frame_t      last_frame,
    output int                       n_taken
);
    // Ready moves only at an edge, and a frame counts where valid and ready meet.
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            out_ready  <= 1'h0;
            last_frame <= '0;
            n_taken    <= 0;
        end else begin
            out_ready <= !stall;
            if (out_valid && out_ready) begin
                last_frame <= out_data;
                n_taken    <= n_taken + 1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking testbench of the waveform source selector.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam logic [63:0] LV = 64'hABCF_123A_7FF5_800F;
    logic                mclk            = 1'h0;
    logic                rst             = 1'h1;
    logic                cfg_wr          = 1'h0;
    logic                cfg_rd          = 1'h0;
    logic                run             = 1'h0;
    logic                stall           = 1'h0;
    logic [7:0]          cfg_addr        = 8'h00;
    logic [15:0]         cfg_wdata       = 16'h0000;
    logic [15:0]         pattern_period  = 16'h0010;
    logic [3:0][15:0]    fixed_level_reg = LV;
    logic [3:0][15:0]    launch_delay    = '0;
    dwg_pkg::dwg_frame_t ram_data        = 48'h4443_3322_2111;
    dwg_pkg::dwg_frame_t ramp_data       = 48'hA04A_03A0_2A01;
    dwg_pkg::dwg_frame_t synth_data      = 48'h5B45_B35B_25B1;
    dwg_pkg::dwg_frame_t out_data;
    dwg_pkg::dwg_frame_t last_frame;
    dwg_pkg::dwg_frame_t f;
    dwg_pkg::dwg_frame_t g;
    logic [15:0]         cfg_rdata;
    logic                ram_advance;
    logic                out_valid;
    logic                out_ready;
    logic                pattern_active;
    int                  n_taken;
    int                  n_mismatch      = 0;
    int                  n_checks        = 0;

    always #25 mclk = ~mclk;

    dwg_source_select dut (
        .mclk(mclk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .run(run),
        .fixed_level_reg(fixed_level_reg), .launch_delay(launch_delay),
        .pattern_period(pattern_period), .ram_data(ram_data), .ramp_data(ramp_data),
        .synth_data(synth_data), .ram_advance(ram_advance), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data), .pattern_active(pattern_active)
    );
    dwg_sink_model sink (
        .mclk(mclk), .rst(rst), .stall(stall), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data), .last_frame(last_frame),
        .n_taken(n_taken)
    );

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int n = 1);
        repeat (n) @(posedge mclk);
        #5;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic fcmp(input dwg_pkg::dwg_frame_t a, input dwg_pkg::dwg_frame_t b);
        n_checks++;
        if (a !== b) begin
            n_mismatch++;
            $display("[FAIL] %0t frame %h expected %h", $time, a, b);
        end
    endtask
    // Each access leaves one idle edge so a strobe is never set twice in one step.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        cfg_addr  = a;
        cfg_wdata = d;
        cfg_wr    = 1'h1;
        tick();
        cfg_wr = 1'h0;
        tick();
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        cfg_addr = a;
        cfg_rd   = 1'h1;
        tick();
        cfg_rd = 1'h0;
        tick();
        check(cfg_rdata, exp);
    endtask
    function automatic logic [15:0] sel(input logic [1:0] s, input logic [1:0] b);
        return {2'h0, b, 2'h0, s, 2'h0, b, 2'h0, s};
    endfunction
    task automatic cfg2(input logic [1:0] s, input logic [1:0] b);
        wr(8'h26, sel(s, b));
        wr(8'h27, sel(s, b));
    endtask
    // Old frames may still sit in the buffer, so several are drained first.
    task automatic frames(input int n);
        int s;
        s = n_taken;
        for (int k = 0; k < 400 && n_taken < s + n; k++) tick();
        f = last_frame;
        if (n_taken < s + n) begin
            n_mismatch++;
            $display("[FAIL] %0t no frames", $time);
            stop_test();
        end
    endtask
    task automatic gap(input logic [15:0] exp);
        int k;
        tick(20);
        for (k = 0; k < 40 && ram_advance !== 1'h1; k++) tick();
        tick();
        for (k = 1; k < 40 && ram_advance !== 1'h1; k++) tick();
        if (ram_advance !== 1'h1) begin
            n_mismatch++;
            $display("[FAIL] %0t no address advance", $time);
            stop_test();
        end else begin
            check(k[15:0], exp);
        end
    endtask

    task automatic t_regs();
        rd_chk(8'h26, 16'h0101);
        rd_chk(8'h27, 16'h0101);
        rd_chk(8'h28, 16'h0111);
        rd_chk(8'h29, 16'h0000);
        wr(8'h26, 16'hFFFF);
        wr(8'h27, 16'hFFFF);
        wr(8'h28, 16'hFFFF);
        wr(8'h29, 16'h1234);
        rd_chk(8'h26, 16'h3333);
        rd_chk(8'h27, 16'h3F3F);
        rd_chk(8'h28, 16'h0FFF);
        wr(8'h28, 16'h0111);
    endtask
    task automatic t_sources();
        cfg2(2'h1, 2'h0);
        frames(6);
        fcmp(f, 48'hABC1_237F_F800);
        cfg2(2'h1, 2'h1);
        frames(6);
        fcmp(f, ramp_data);
        cfg2(2'h1, 2'h3);
        frames(6);
        fcmp(f, synth_data);
        cfg2(2'h0, 2'h0);
        frames(6);
        fcmp(f, ram_data);
    endtask
    task automatic t_modes23();
        ram_data = '0;
        cfg2(2'h3, 2'h0);
        frames(6);
        fcmp(f, '0);
        launch_delay   = {4{16'hFFFF}};
        pattern_period = 16'hFFFF;
        wr(8'h28, 16'h0110);
        cfg2(2'h2, 2'h0);
        frames(6);
        fcmp(f, '0);
        launch_delay   = '0;
        frames(6);
        fcmp(f, 48'hABC1_237F_F800);
        pattern_period = 16'h0010;
        ram_data       = 48'h4443_3322_2111;
        wr(8'h28, 16'h0111);
    endtask
    task automatic t_force();
        wr(8'h26, sel(2'h0, 2'h0));
        wr(8'h27, sel(2'h1, 2'h0) | 16'h0808);
        frames(6);
        fcmp(f, 48'hABC1_237F_F800);
        wr(8'h27, sel(2'h1, 2'h0));
        frames(6);
        fcmp(f, 48'h4443_337F_F800);
    endtask
    task automatic t_sum();
        fixed_level_reg = 64'h00F0_0FF0_7F00_1000;
        cfg2(2'h1, 2'h0);
        wr(8'h27, sel(2'h1, 2'h0) | 16'h0404);
        frames(6);
        fcmp(f, 48'h00F0_FF7F_F1FF);
        wr(8'h27, sel(2'h1, 2'h0) | 16'h0004);
        frames(6);
        fcmp(f, 48'h00F0_FF7F_01FF);
        fixed_level_reg = LV;
    endtask
    task automatic t_noise_stall();
        cfg2(2'h1, 2'h2);
        frames(6);
        g = f;
        frames(1);
        n_checks++;
        if (f.ch[0] === g.ch[0]) begin
            n_mismatch++;
            $display("[FAIL] %0t noise did not move", $time);
        end
        stall = 1'h1;
        tick(10);
        check({15'h0000, out_valid}, 16'h0001);
        g = out_data;
        tick(8);
        fcmp(out_data, g);
        stall = 1'h0;
        frames(1);
        fcmp(f, g);
    endtask
    task automatic t_hold_run();
        cfg2(2'h0, 2'h0);
        wr(8'h28, 16'h0311);
        gap(16'h0003);
        wr(8'h28, 16'h0011);
        gap(16'h0010);
        wr(8'h28, 16'h0111);
        check({15'h0000, pattern_active}, 16'h0001);
        run = 1'h0;
        tick(10);
        repeat (5) begin
            check({13'h0000, out_valid, pattern_active, ram_advance}, 16'h0000);
            tick(3);
        end
        run = 1'h1;
        frames(2);
    endtask

    initial begin
        tick(16);
        rst = 1'h0;
        tick();
        run = 1'h1;
        t_regs();
        t_sources();
        t_modes23();
        t_force();
        t_sum();
        t_noise_stall();
        t_hold_run();
        stop_test();
    end
endmodule
`default_nettype wire
